// [design/pcr_defs.svh]
// Purpose: Offsets, reset values, write masks and field positions of the
//          PLL control register bank.
// Assumes: Byte-wide registers addressed by a 13-bit register address.
// Notes:   Definitions only; included by bare name.
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// Register address width
`define PCR_ADDR_W 13

// Register offsets
`define PCR_OFS_SERIAL_PORT_CONTROL        13'h0000
`define PCR_OFS_READBACK_SELECT            13'h0004
`define PCR_OFS_BUFFER_TRANSFER_STROBE     13'h0005
`define PCR_OFS_PUMP_CURRENT_LEVEL         13'h000A
`define PCR_OFS_PUMP_DETECTOR_MODE         13'h000B
`define PCR_OFS_PUMP_OFFSET_CONTROL        13'h000C
`define PCR_OFS_BACKLASH_LOCKDET_CONTROL   13'h000D
`define PCR_OFS_OSCILLATOR_CAL_CONTROL     13'h000E
`define PCR_OFS_OSCILLATOR_AMPLITUDE       13'h000F
`define PCR_OFS_OSCILLATOR_BAND            13'h0010
`define PCR_OFS_FEEDBACK_INTEGER_DIVIDE    13'h0011
`define PCR_OFS_MODULUS_HIGH               13'h0012
`define PCR_OFS_MODULUS_MIDDLE             13'h0013
`define PCR_OFS_MODULUS_LOW_LOOP_CONTROL   13'h0014
`define PCR_OFS_FRACTION_HIGH              13'h0015
`define PCR_OFS_FRACTION_MIDDLE            13'h0016
`define PCR_OFS_FRACTION_LOW_DIVIDER_MSB   13'h0017
`define PCR_OFS_OUTPUT_DIVIDER_VALUES      13'h0018
`define PCR_OFS_OUTPUT_DIVIDER_OVERRIDE    13'h0019
`define PCR_OFS_RECEIVER_REFERENCE_VOLTAGE 13'h001A
`define PCR_OFS_RESONATOR_TUNING           13'h001B

// Fixed read values of the serial port control register
`define PCR_SPC_RESET 8'h18

// Stored registers in cell order: offsets, reset values, writable bits
`define PCR_CELL_ADDRS '{`PCR_OFS_SERIAL_PORT_CONTROL, `PCR_OFS_READBACK_SELECT, \
    `PCR_OFS_PUMP_CURRENT_LEVEL, `PCR_OFS_PUMP_DETECTOR_MODE, \
    `PCR_OFS_PUMP_OFFSET_CONTROL, `PCR_OFS_BACKLASH_LOCKDET_CONTROL, \
    `PCR_OFS_OSCILLATOR_CAL_CONTROL, `PCR_OFS_OSCILLATOR_AMPLITUDE, \
    `PCR_OFS_OSCILLATOR_BAND, `PCR_OFS_FEEDBACK_INTEGER_DIVIDE, \
    `PCR_OFS_MODULUS_HIGH, `PCR_OFS_MODULUS_MIDDLE, `PCR_OFS_MODULUS_LOW_LOOP_CONTROL, \
    `PCR_OFS_FRACTION_HIGH, `PCR_OFS_FRACTION_MIDDLE, `PCR_OFS_FRACTION_LOW_DIVIDER_MSB, \
    `PCR_OFS_OUTPUT_DIVIDER_VALUES, `PCR_OFS_OUTPUT_DIVIDER_OVERRIDE, \
    `PCR_OFS_RECEIVER_REFERENCE_VOLTAGE, `PCR_OFS_RESONATOR_TUNING}
`define PCR_CELL_RESETS '{8'h00, 8'h00, 8'h80, 8'h30, 8'h00, 8'h00, 8'h70, 8'h80, \
    8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00, 8'h80}
`define PCR_CELL_MASKS '{8'h40, 8'h01, 8'hFF, 8'hFF, 8'h78, 8'hC1, 8'hFF, 8'hFC, \
    8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF1, 8'hFF, 8'hA0, 8'hFD, 8'hBF}

// Field positions
`define PCR_SPC_LSB_FIRST_BIT   6
`define PCR_SPC_SOFT_RESET_BIT  5
`define PCR_READBACK_BIT        0
`define PCR_STROBE_BIT          0
`define PCR_PUMP_CURRENT_OVR_BIT 7
`define PCR_BACKLASH_OVR_BIT    6
`define PCR_PUMP_MODE_LSB       4
`define PCR_PUMP_MODE_OVR_BIT   3
`define PCR_FEEDBACK_EDGE_BIT   2
`define PCR_REFERENCE_EDGE_BIT  1
`define PCR_MIDSCALE_BIT        0
`define PCR_OFFSET_DIR_BIT      6
`define PCR_OFFSET_MAG_LSB      4
`define PCR_OFFSET_OVR_BIT      3
`define PCR_BACKLASH_CODE_LSB   6
`define PCR_LOCKDET_PD_BIT      0
`define PCR_CAL_REQUEST_BIT     7
`define PCR_RX_RESET_BIT        7

`endif

// [design/pcr_pkg.sv]
// Purpose: Types of the PLL control register bank.
// Assumes: Constants live in pcr_defs.svh.
// Notes:   Analog map mirrors registers 0x0E to 0x1B bit for bit.
package pcr_pkg;

    // Settings chosen by the automatic loop logic
    typedef struct packed {
        logic [7:0] pump_current;
        logic [1:0] backlash_period;
        logic [1:0] pump_mode_code;
        logic       offset_down;
        logic [7:0] offset_current;
    } pcr_auto_s;

    // Effective settings driven into the loop
    typedef struct packed {
        logic [7:0] pump_current;
        logic [1:0] backlash_period;
        logic [1:0] pump_mode_code;
        logic       offset_down;
        logic [7:0] offset_current;
        logic       feedback_falling;
        logic       reference_falling;
        logic       force_midscale;
        logic       lockdet_powerdown;
    } pcr_pll_ctrl_s;

    // Active oscillator, divider, receiver and resonator fields
    typedef struct packed {
        logic        cal_request;
        logic        amplitude_regulation_auto;
        logic [2:0]  alc_threshold;
        logic        cal_manual;
        logic        supply_boost;
        logic        band_manual;
        logic [5:0]  amplitude_level;
        logic [1:0]  unused_amp;
        logic [6:0]  band;
        logic        unused_band;
        logic [7:0]  integer_divide;
        logic [19:0] modulus_value;
        logic        output_freq_manual;
        logic        fraction_modulator_bypass;
        logic        fraction_modulator_disable;
        logic        pll_reset;
        logic [19:0] fraction_value;
        logic [2:0]  unused_fraction_value;
        logic [5:0]  second_stage_divider;
        logic [2:0]  first_stage_divider;
        logic        divider_manual;
        logic [6:0]  unused_div;
        logic        receiver_reset;
        logic [4:0]  bandgap_adjust;
        logic        unused_bandgap;
        logic        bandgap_manual;
        logic        resonator_auto;
        logic        unused_resonator;
        logic [5:0]  resonator_tuning;
    } pcr_analog_s;

    // State of one register cell
    typedef struct packed {
        logic [7:0] buffered;
        logic [7:0] active;
    } pcr_cell_state_s;

    // State of the bank
    typedef struct packed {
        logic          soft_reset_pending;
        logic          update_pending;
        logic [7:0]    rdata;
        logic          rvalid;
        logic [1:0]    done_meta;
        logic [1:0]    done_sync;
        pcr_pll_ctrl_s pll_ctrl;
    } pcr_bank_state_s;

endpackage

// [design/pcr_reg_cell.sv]
// Purpose: One byte register with a serial buffer and an active copy.
// Assumes: Writes, update, soft reset and clears are same-clock pulses.
// Notes:   Unbuffered cells load the active copy directly on a write.
module pcr_reg_cell
    import pcr_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hFF,
    parameter bit         BUFFERED    = 1'b1
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Controls
    input  wire logic       soft_reset,
    input  wire logic       write_en,
    input  wire logic [7:0] write_data,
    input  wire logic       update,
    input  wire logic [7:0] clear_mask,
    // Contents
    output logic [7:0]      buffered_value,
    output logic [7:0]      active_value
);
    localparam logic [7:0] STORED_RESET = RESET_VALUE & WRITE_MASK;

    pcr_cell_state_s state;
    pcr_cell_state_s next_state;

    // Clear first, then write and update so a new set wins over a clear
    always_comb begin
        next_state = state;
        next_state.buffered = state.buffered & ~clear_mask;
        next_state.active = state.active & ~clear_mask;
        if (write_en) begin
            next_state.buffered = (next_state.buffered & ~WRITE_MASK) |
                                  (write_data & WRITE_MASK);
        end
        if (!BUFFERED) begin
            next_state.active = next_state.buffered;
        end else if (update) begin
            next_state.active = state.buffered;
        end
        if (soft_reset) begin
            next_state.buffered = STORED_RESET;
            next_state.active = STORED_RESET;
        end
    end

    // State register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= {STORED_RESET, STORED_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign buffered_value = state.buffered;
    assign active_value = state.active;
endmodule

// [design/pcr_bank.sv]
// Purpose: Control register bank of a fractional-N PLL clock generator.
// Assumes: A serial engine on the same clock decodes frames and presents
//          one byte access at a time on the register access port.
// Notes:   Unmapped addresses read zero and ignore writes.
// Behaviour
// - Autoclearing bits clear themselves when done
// - Port control bit 7 reads zero
// - Port control bit 4 reads one
// - Port control low nibble mirrors high nibble
// - Bit 6 selects least-significant-first order
// - Soft reset restores defaults, then self-clears
// - Readback select picks active or buffered values
// - Update strobe copies buffers to active, self-clears
// - Pump current field sets pump current only when overridden
// - Pump current override chooses field or automatic
// - Backlash override applies two-bit period code
// - Pump mode override applies two-bit mode code
// - Bit 2 picks feedback active edge
// - Bit 1 picks reference active edge
// - Bit 0 holds oscillator at midscale
// - Offset direction applies only when overridden
// - Offset magnitude scales programmed current by half..sixteenth
// - Offset override chooses programmed or automatic offset
// - Lock detector powers down when bit set
`include "pcr_defs.svh"

module pcr_bank
    import pcr_pkg::*;
#(
    parameter int NUM_CELLS = 20
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Register access from the serial engine
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    input  wire logic [`PCR_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]              reg_wdata,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    // Bit order for the serial engine
    output logic                         lsb_first,
    // Settings proposed by the automatic loop logic
    input  wire pcr_auto_s               auto_settings,
    // Task completion pins of the analog side
    input  wire logic                    cal_done,
    input  wire logic                    rx_reset_done,
    // Control outputs
    output pcr_pll_ctrl_s                pll_ctrl,
    output pcr_analog_s                  analog_ctrl,
    output logic                         soft_reset_pulse,
    output logic                         update_pulse
);
    // Cell indices of registers with behaviour of their own
    localparam int IX_SPC = 0;
    localparam int IX_READBACK = 1;
    localparam int IX_PUMP_CURRENT = 2;
    localparam int IX_DETECTOR_MODE = 3;
    localparam int IX_OFFSET = 4;
    localparam int IX_BACKLASH = 5;
    localparam int IX_CAL = 6;
    localparam int IX_RX_REF = 18;
    localparam int IX_ANALOG_LO = 6;
    localparam int IX_ANALOG_HI = 19;

    // Register layout tables
    localparam logic [`PCR_ADDR_W-1:0] CELL_ADDR [NUM_CELLS] = `PCR_CELL_ADDRS;
    localparam logic [7:0] CELL_RESET [NUM_CELLS] = `PCR_CELL_RESETS;
    localparam logic [7:0] CELL_MASK [NUM_CELLS] = `PCR_CELL_MASKS;

    pcr_bank_state_s state;
    pcr_bank_state_s next_state;

    logic [7:0] buf_val [NUM_CELLS];
    logic [7:0] act_val [NUM_CELLS];
    logic [7:0] clear_mask [NUM_CELLS];
    logic [NUM_CELLS-1:0] cell_write;
    logic soft_reset;
    logic update;
    logic readback_buffered;
    logic cal_done_s;
    logic rx_done_s;
    logic [7:0] spc_active;
    logic [7:0] spc_buffered;
    logic [7:0] pump_level;
    logic [7:0] mode_reg;
    logic [7:0] offset_reg;
    logic [7:0] backlash_reg;

    // One-cycle actions come from the pending flags of the previous write
    assign soft_reset = state.soft_reset_pending;
    assign update = state.update_pending;
    assign readback_buffered = act_val[IX_READBACK][`PCR_READBACK_BIT];
    assign cal_done_s = state.done_sync[0];
    assign rx_done_s = state.done_sync[1];

    // Serial port control as read: forced bits and a mirrored nibble
    always_comb begin
        spc_active = 8'h00;
        spc_active[`PCR_SPC_LSB_FIRST_BIT] =
            act_val[IX_SPC][`PCR_SPC_LSB_FIRST_BIT];
        spc_active[`PCR_SPC_SOFT_RESET_BIT] = state.soft_reset_pending;
        spc_active = spc_active | `PCR_SPC_RESET;
        spc_active[3:0] = {<<{spc_active[7:4]}};
        spc_buffered = 8'h00;
        spc_buffered[`PCR_SPC_LSB_FIRST_BIT] =
            buf_val[IX_SPC][`PCR_SPC_LSB_FIRST_BIT];
        spc_buffered[`PCR_SPC_SOFT_RESET_BIT] = state.soft_reset_pending;
        spc_buffered = spc_buffered | `PCR_SPC_RESET;
        spc_buffered[3:0] = {<<{spc_buffered[7:4]}};
    end

    // Per-cell write decode; writes during a soft reset cycle are dropped
    generate
        for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
            assign cell_write[i] = reg_write && !soft_reset &&
                                   (reg_addr == CELL_ADDR[i]);
            pcr_reg_cell #(
                .RESET_VALUE (CELL_RESET[i]),
                .WRITE_MASK  (CELL_MASK[i]),
                .BUFFERED    (i != IX_READBACK)
            ) u_cell (
                .clock          (clock),
                .reset_n        (reset_n),
                .soft_reset     (soft_reset),
                .write_en       (cell_write[i]),
                .write_data     (reg_wdata),
                .update         (update),
                .clear_mask     (clear_mask[i]),
                .buffered_value (buf_val[i]),
                .active_value   (act_val[i])
            );
        end
    endgenerate

    // Autoclearing task bits drop once the analog side reports completion
    always_comb begin
        for (int i = 0; i < NUM_CELLS; i++) begin
            clear_mask[i] = 8'h00;
        end
        if (cal_done_s && act_val[IX_CAL][`PCR_CAL_REQUEST_BIT]) begin
            clear_mask[IX_CAL][`PCR_CAL_REQUEST_BIT] = 1'b1;
        end
        if (rx_done_s && act_val[IX_RX_REF][`PCR_RX_RESET_BIT]) begin
            clear_mask[IX_RX_REF][`PCR_RX_RESET_BIT] = 1'b1;
        end
    end

    // Active loop control fields
    assign pump_level = act_val[IX_PUMP_CURRENT];
    assign mode_reg = act_val[IX_DETECTOR_MODE];
    assign offset_reg = act_val[IX_OFFSET];
    assign backlash_reg = act_val[IX_BACKLASH];

    // Next state of the bank
    always_comb begin
        logic [7:0] rd;
        logic [1:0] mag;
        rd = 8'h00;
        mag = offset_reg[`PCR_OFFSET_MAG_LSB +: 2];
        next_state = state;

        // Pin synchronisers: the first stage feeds only the second
        next_state.done_meta = {rx_reset_done, cal_done};
        next_state.done_sync = state.done_meta;

        // Soft reset and update last one cycle, a new write of one wins outside a soft reset cycle
        next_state.soft_reset_pending = 1'b0;
        next_state.update_pending = 1'b0;
        if (reg_write && !soft_reset) begin
            if (reg_addr == `PCR_OFS_SERIAL_PORT_CONTROL) begin
                next_state.soft_reset_pending =
                    reg_wdata[`PCR_SPC_SOFT_RESET_BIT];
            end else if (reg_addr == `PCR_OFS_BUFFER_TRANSFER_STROBE) begin
                next_state.update_pending = reg_wdata[`PCR_STROBE_BIT];
            end
        end
        if (soft_reset) begin
            next_state.update_pending = 1'b0;
        end

        // Read decode; buffered cells follow the readback select
        if (reg_addr == `PCR_OFS_SERIAL_PORT_CONTROL) begin
            rd = readback_buffered ? spc_buffered : spc_active;
        end else if (reg_addr == `PCR_OFS_BUFFER_TRANSFER_STROBE) begin
            rd = 8'h00;
            rd[`PCR_STROBE_BIT] = state.update_pending;
        end else if (reg_addr == `PCR_OFS_READBACK_SELECT) begin
            rd = act_val[IX_READBACK];
        end else begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                if (reg_addr == CELL_ADDR[i]) begin
                    rd = readback_buffered ? buf_val[i] : act_val[i];
                end
            end
        end
        next_state.rvalid = reg_read;
        if (reg_read) begin
            next_state.rdata = rd;
        end

        // Pump current: programmed field only under override
        if (mode_reg[`PCR_PUMP_CURRENT_OVR_BIT]) begin
            next_state.pll_ctrl.pump_current = pump_level;
        end else begin
            next_state.pll_ctrl.pump_current = auto_settings.pump_current;
        end

        // Antibacklash period
        if (mode_reg[`PCR_BACKLASH_OVR_BIT]) begin
            next_state.pll_ctrl.backlash_period =
                backlash_reg[`PCR_BACKLASH_CODE_LSB +: 2];
        end else begin
            next_state.pll_ctrl.backlash_period = auto_settings.backlash_period;
        end

        // Pump mode: tristate, up, down or normal
        if (mode_reg[`PCR_PUMP_MODE_OVR_BIT]) begin
            next_state.pll_ctrl.pump_mode_code =
                mode_reg[`PCR_PUMP_MODE_LSB +: 2];
        end else begin
            next_state.pll_ctrl.pump_mode_code = auto_settings.pump_mode_code;
        end

        // Offset current scales the programmed field by a power of two
        if (offset_reg[`PCR_OFFSET_OVR_BIT]) begin
            next_state.pll_ctrl.offset_down = offset_reg[`PCR_OFFSET_DIR_BIT];
            case (mag)
                2'h0: next_state.pll_ctrl.offset_current = {1'b0, pump_level[7:1]};
                2'h1: next_state.pll_ctrl.offset_current = {2'h0, pump_level[7:2]};
                2'h2: next_state.pll_ctrl.offset_current = {3'h0, pump_level[7:3]};
                default: next_state.pll_ctrl.offset_current = {4'h0, pump_level[7:4]};
            endcase
        end else begin
            next_state.pll_ctrl.offset_down = auto_settings.offset_down;
            next_state.pll_ctrl.offset_current = auto_settings.offset_current;
        end

        // Edge selects, midscale hold and lock detector power
        next_state.pll_ctrl.feedback_falling = mode_reg[`PCR_FEEDBACK_EDGE_BIT];
        next_state.pll_ctrl.reference_falling = mode_reg[`PCR_REFERENCE_EDGE_BIT];
        next_state.pll_ctrl.force_midscale = mode_reg[`PCR_MIDSCALE_BIT];
        next_state.pll_ctrl.lockdet_powerdown = backlash_reg[`PCR_LOCKDET_PD_BIT];
    end

    // Bank state register; reset values mirror the register defaults except pump current and offset current, which reset to zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.pll_ctrl.pump_mode_code <= 2'h3;
        end else begin
            state <= next_state;
        end
    end

    // Analog map packed from the active copies of 0x0E to 0x1B
    always_comb begin
        logic [8*(IX_ANALOG_HI-IX_ANALOG_LO+1)-1:0] flat;
        flat = '0;
        for (int i = IX_ANALOG_LO; i <= IX_ANALOG_HI; i++) begin
            flat[8*(IX_ANALOG_HI-i) +: 8] = act_val[i];
        end
        analog_ctrl = pcr_analog_s'(flat);
    end

    // Outputs
    assign reg_rdata = state.rdata;
    assign reg_rvalid = state.rvalid;
    assign lsb_first = act_val[IX_SPC][`PCR_SPC_LSB_FIRST_BIT];
    assign pll_ctrl = state.pll_ctrl;
    assign soft_reset_pulse = soft_reset;
    assign update_pulse = update;
endmodule

// [tb/pcr_bank_checker.sv]
// Purpose: Port checks of the bank.
// Assumes: Bound to pcr_bank.
// Notes:   Edge, midscale and lock detector outputs move only after a transfer or soft reset.
module pcr_bank_checker
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic          clock,
    input wire logic          reset_n,
    // Access port
    input wire logic          reg_write,
    input wire logic          reg_read,
    input wire logic [12:0]   reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic [7:0]    reg_rdata,
    input wire logic          reg_rvalid,
    // Controls and pins
    input wire logic          lsb_first,
    input wire logic          cal_done,
    input wire pcr_pll_ctrl_s pll_ctrl,
    input wire pcr_analog_s   analog_ctrl,
    input wire logic          soft_reset_pulse,
    input wire logic          update_pulse
);
    // One domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_rvalid; reg_rvalid == $past(reg_read); endproperty
    a_rvalid: assert property (p_rvalid) else $error("rvalid wrong");
    property p_spc; reg_rvalid && $past(reg_addr) == 13'h0000 |-> !reg_rdata[7]
        && reg_rdata[4] && reg_rdata[3:0] == {<<{reg_rdata[7:4]}}; endproperty
    a_spc: assert property (p_spc) else $error("port control read wrong");
    property p_soft; reg_write && reg_addr == 13'h0000 && reg_wdata[5] && !soft_reset_pulse
        |=> soft_reset_pulse ##1 !soft_reset_pulse; endproperty
    a_soft: assert property (p_soft) else $error("soft reset pulse");
    property p_update; reg_write && reg_addr == 13'h0005 && !soft_reset_pulse
        |=> update_pulse == $past(reg_wdata[0]) ##1 (!update_pulse || $past(reg_write)); endproperty
    a_update: assert property (p_update) else $error("update pulse");
    property p_order; $changed(lsb_first) |-> $past(update_pulse) || $past(soft_reset_pulse);
    endproperty
    a_order: assert property (p_order) else $error("order moved alone");
    property p_pll; $changed({pll_ctrl.feedback_falling, pll_ctrl.reference_falling,
        pll_ctrl.force_midscale, pll_ctrl.lockdet_powerdown})
        |-> $past(update_pulse, 2) || $past(soft_reset_pulse, 2); endproperty
    a_pll: assert property (p_pll) else $error("loop moved alone");
    property p_cal; cal_done && analog_ctrl.cal_request && !reg_write
        |-> ##[1:6] !analog_ctrl.cal_request; endproperty
    a_cal: assert property (p_cal) else $error("cal not cleared");
    property p_unused; analog_ctrl.unused_amp == 2'h0 && !analog_ctrl.unused_band
        && analog_ctrl.unused_fraction_value == 3'h0 && !analog_ctrl.unused_resonator; endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    // Main scenarios reached
    c_update: cover property (update_pulse);
    c_soft: cover property (soft_reset_pulse);
    c_cal: cover property ($fell(analog_ctrl.cal_request));
endmodule
bind pcr_bank pcr_bank_checker u_checker (.*);

// [tb/pcr_host_model.sv]
// Purpose: Host side of the register access port.
// Assumes: One byte per request, at falling edges.
// Notes:   Released lines show inverted values.
module pcr_host_model (
    // Clock
    input  wire logic       clock,
    // Access port
    output logic            reg_write,
    output logic            reg_read,
    output logic [12:0]     reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle port
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 13'h0000;
        reg_wdata = 8'h00;
    end
    // Write one byte
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Read one byte; X if no answer
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
    // Order change plus transfer
    task automatic set_order(input logic [7:0] d);
        wr(13'h0000, d);
        wr(13'h0005, 8'h01);
    endtask
endmodule

// [tb/pcr_bank_bench.sv]
// Purpose: Self-checking bench of the bank.
// Assumes: Host model drives the port.
// Notes:   Pin waits cover the synchroniser.
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: got %h want %h", $time, (act), (exp)); end end
module pcr_bank_bench
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam pcr_auto_s AUTO = '{8'h3C, 2'h1, 2'h2, 1'b0, 8'h11};
    logic          clock, reset_n, reg_write, reg_read, reg_rvalid, lsb_first;
    logic          cal_done, rx_reset_done, soft_reset_pulse, update_pulse;
    logic [12:0]   reg_addr;
    logic [7:0]    reg_wdata, reg_rdata, rb;
    pcr_auto_s     auto_settings;
    pcr_pll_ctrl_s pll_ctrl;
    pcr_analog_s   analog_ctrl;
    int            err_total = 0;
    int            total_checks = 0;

    pcr_bank DUT (.*);
    pcr_host_model host (.*);

    // Clock and verdict helpers
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
        host.rd(a, rb);
        `CHK(rb, e)
    endtask
    // Transfer and settle
    task automatic upd();
        host.wr(13'h0005, 8'h01);
        repeat (3) @(negedge clock);
    endtask
    task automatic t_reset();
        rdchk(13'h0000, 8'h18);
        rdchk(13'h000A, 8'h80);
        rdchk(13'h000B, 8'h30);
        rdchk(13'h0019, 8'h20);
        rdchk(13'h001B, 8'h80);
        `CHK(pll_ctrl.pump_current, AUTO.pump_current)
        `CHK(pll_ctrl.offset_current, AUTO.offset_current)
        $display("test reset done");
    endtask
    task automatic t_order();
        host.set_order(8'hDF);
        @(negedge clock);
        `CHK(lsb_first, 1'b1)
        rdchk(13'h0000, 8'h5A);
        host.set_order(8'h00);
        @(negedge clock);
        `CHK(lsb_first, 1'b0)
        $display("test order done");
    endtask
    // Buffer view and refusals
    task automatic t_buffer();
        host.wr(13'h000A, 8'h55);
        rdchk(13'h000A, 8'h80);
        host.wr(13'h0004, 8'hFF);
        rdchk(13'h0004, 8'h01);
        rdchk(13'h000A, 8'h55);
        upd();
        rdchk(13'h0005, 8'h00);
        host.wr(13'h0004, 8'h00);
        host.wr(13'h000A, 8'h66);
        host.wr(13'h0005, 8'h00);
        rdchk(13'h000A, 8'h55);
        host.wr(13'h000A, 8'h55);
        upd();
        `CHK(pll_ctrl.pump_current, AUTO.pump_current)
        host.wr(13'h0030, 8'hFF);
        rdchk(13'h0030, 8'h00);
        $display("test buffer done");
    endtask
    // Override codes
    task automatic t_override();
        for (int i = 0; i < 4; i++) begin
            host.wr(13'h000B, 8'hC8 | 8'(i << 4));
            host.wr(13'h000C, 8'h08 | 8'(i << 4));
            host.wr(13'h000D, 8'(i << 6));
            upd();
            `CHK(pll_ctrl.pump_mode_code, 2'(i))
            `CHK(pll_ctrl.backlash_period, 2'(i))
            `CHK(pll_ctrl.offset_current, 8'h55 >> (i + 1))
            `CHK(pll_ctrl.pump_current, 8'h55)
        end
        host.wr(13'h000B, 8'h07);
        host.wr(13'h000C, 8'h48);
        host.wr(13'h000D, 8'h3F);
        upd();
        `CHK(pll_ctrl.pump_current, AUTO.pump_current)
        `CHK({pll_ctrl.feedback_falling, pll_ctrl.reference_falling}, 2'h3)
        `CHK(pll_ctrl.force_midscale, 1'b1)
        `CHK(pll_ctrl.lockdet_powerdown, 1'b1)
        `CHK(pll_ctrl.offset_down, 1'b1)
        `CHK(pll_ctrl.pump_mode_code, AUTO.pump_mode_code)
        `CHK(pll_ctrl.backlash_period, AUTO.backlash_period)
        rdchk(13'h000D, 8'h01);
        $display("test override done");
    endtask
    // Autoclear on done pins
    task automatic t_aclr();
        host.wr(13'h000E, 8'hF4);
        host.wr(13'h001A, 8'h80);
        upd();
        `CHK({analog_ctrl.cal_request, analog_ctrl.receiver_reset}, 2'h3)
        {cal_done, rx_reset_done} = 2'h3;
        repeat (6) @(negedge clock);
        `CHK({analog_ctrl.cal_request, analog_ctrl.receiver_reset}, 2'h0)
        rdchk(13'h000E, 8'h74);
        {cal_done, rx_reset_done} = 2'h0;
        $display("test aclr done");
    endtask
    task automatic t_soft();
        host.wr(13'h0000, 8'h20);
        repeat (3) @(negedge clock);
        rdchk(13'h0000, 8'h18);
        rdchk(13'h000A, 8'h80);
        rdchk(13'h000B, 8'h30);
        `CHK(pll_ctrl.force_midscale, 1'b0)
        $display("test soft done");
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        cal_done = 1'b0;
        rx_reset_done = 1'b0;
        auto_settings = AUTO;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        t_reset();
        t_order();
        t_buffer();
        t_override();
        t_aclr();
        t_soft();
        print_verdict();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        print_verdict();
    end
endmodule
